//--- core/jlsd_demapper.sv
// Transport-layer demapper: lane octets of one frame to converter samples.
// Assumes one whole frame of all used lanes per beat, octet 0 lowest.
//
// Notes on behaviour
// RULE1: each lane octet carries one fixed sample slice
// RULE2: mode 3 lane n is converter n
// RULE3: mode 4 lane n is converter n
// RULE4: mode 9 lane pairs per converter, even/odd
// RULE5: mode 11 four lanes per converter, samples 0-3
// RULE6: mode 19 lane n holds sample n
// RULE7: mode 21 lane n holds sample n
// RULE8: 12-bit nibble packing, two samples, MSN first
// RULE9: mode 5 one lane, converter 0 then 1
// RULE10: mode 6 lane 0 converters 0-1, lane 1 2-3
// RULE11: mode 22 two consecutive samples per lane
// RULE12: mode 12 lane k holds samples 2k, 2k+1
// RULE13: mode 0 converter 0 octets 0-1, 1 octets 2-3
// RULE14: mode 1 two converters per lane
// RULE15: mode 2 lane n converters 2n, 2n+1
// RULE16: mode 7 four converters in octet order
// RULE17: misaligned lanes drop sync request; transmitter resends sync
// RULE18: samples ascending per converter; mode from configuration
`timescale 1ns/10ps
module jlsd_demapper (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [4:0] cfg_link_mode,
  input wire logic [7:0] lane_aligned,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [jlsd_pkg::JLSD_IN_W-1:0] in_octets,
  output logic link_sync_request,
  output logic mode_error,
  output logic smp_valid,
  input wire logic smp_ready,
  output logic [jlsd_pkg::JLSD_SMP_W-1:0] smp_data,
  output logic [jlsd_pkg::JLSD_CNT_W-1:0] smp_count,
  output logic [jlsd_pkg::JLSD_SPC_W-1:0] smp_spc,
  output logic [jlsd_pkg::JLSD_CNV_W-1:0] smp_convs
);
  localparam int OW = jlsd_pkg::JLSD_OW;
  localparam int SW = jlsd_pkg::JLSD_SW;
  localparam int NB = jlsd_pkg::JLSD_NIB;
  localparam int LW = jlsd_pkg::JLSD_LANE_W;
  localparam int WW = jlsd_pkg::JLSD_WORD_W;

  // Reset release through two flops
  logic rst_s1_reg;
  logic rst_s2_reg;
  wire rst_n = rst_s2_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Mode is taken from configuration and held one cycle in a register
  logic [4:0] mode_reg;
  logic mode_err_reg;
  jlsd_pkg::jlsd_mode_s cfg;

  assign cfg = jlsd_pkg::jlsd_mode_lookup(mode_reg); // RULE18

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= jlsd_pkg::JLSD_MODE_0;
      mode_err_reg <= 1'b0;
    end else begin
      mode_reg <= cfg_link_mode; // RULE18
      mode_err_reg <= ~cfg.ok;
    end
  end
  assign mode_error = mode_err_reg;

  // Lanes in use, for the sync monitor
  wire [8:0] lane_one_hot = 9'h001 << cfg.lanes;
  wire [7:0] lane_used = 8'(lane_one_hot - 9'h001);
  logic sync_req;

  jlsd_sync_mon u_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .lane_used(lane_used),
    .lane_aligned(lane_aligned),
    .link_sync_request(sync_req)
  );
  assign link_sync_request = sync_req;

  // Slot g of the output is converter g / S, sample g % S; this is also
  // the linear order of samples over lanes, so one index serves both.
  // 16-bit: S_lane = F/2 samples per lane, shift picks lane and pair.
  wire [1:0] sh16 = (cfg.octs == 4'h8) ? 2'h2
                    : ((cfg.octs == 4'h4) ? 2'h1 : 2'h0);
  // Slots in use: lanes * F / 2 for 16-bit, lanes * 2 for 12-bit
  wire [4:0] slots16 = 5'({1'b0, cfg.lanes} << sh16);
  wire [4:0] slots12 = 5'({1'b0, cfg.lanes} << 1);
  wire [4:0] slots = cfg.hd12 ? slots12 : slots16;

  logic [jlsd_pkg::JLSD_SMP_W-1:0] demap;

  genvar g;
  generate
    for (g = 0; g < jlsd_pkg::JLSD_SLOTS; g++) begin : g_slot
      localparam logic [4:0] GI = 5'(g);
      // 16-bit byte-split packing
      wire [4:0] ln16 = GI >> sh16; // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7
      wire [4:0] pmask = 5'((5'h01 << sh16) - 5'h01);
      wire [4:0] pr16 = GI & pmask; // RULE13 RULE14 RULE15 RULE16
      wire [8:0] base16 = 9'(ln16[2:0]) * 9'(LW) + 9'(pr16) * 9'(2 * OW);
      wire [OW-1:0] hi16 = in_octets[base16 +: OW];
      wire [OW-1:0] lo16 = in_octets[9'(base16 + 9'(OW)) +: OW];
      wire [SW-1:0] s16 = {hi16, lo16}; // RULE1
      // 12-bit nibble packing, two samples per lane in three octets
      wire [2:0] ln12 = GI[3:1]; // RULE9 RULE10 RULE11 RULE12
      wire [8:0] base12 = 9'(ln12) * 9'(LW);
      wire [OW-1:0] o0 = in_octets[base12 +: OW];
      wire [OW-1:0] o1 = in_octets[9'(base12 + 9'(OW)) +: OW];
      wire [OW-1:0] o2 = in_octets[9'(base12 + 9'(2 * OW)) +: OW];
      wire [11:0] s12 = GI[0] ? {o1[NB-1:0], o2}
                        : {o0, o1[OW-1:NB]}; // RULE8
      wire used = (GI < slots);
      assign demap[g*SW +: SW] = !used ? '0
                                 : (cfg.hd12 ? {4'h0, s12} : s16);
    end
  endgenerate

  // Frames are accepted and discarded while the link is out of sync or
  // the mode is not supported; the transmitter is sending sync then.
  logic fifo_ready;
  wire take = in_valid & fifo_ready;
  wire keep = take & sync_req & cfg.ok & ~mode_err_reg; // RULE17
  wire [WW-1:0] word = {cfg.convs, cfg.spc, slots, demap};
  wire [WW-1:0] out_word;
  logic out_valid;

  jlsd_fifo #(
    .WIDTH(WW),
    .DEPTH(jlsd_pkg::JLSD_FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .wr_valid(keep),
    .wr_ready(fifo_ready),
    .wr_data(word),
    .rd_valid(out_valid),
    .rd_ready(smp_ready),
    .rd_data(out_word)
  );

  assign in_ready = fifo_ready;
  assign smp_valid = out_valid;
  assign smp_data = out_word[jlsd_pkg::JLSD_F_DATA +: jlsd_pkg::JLSD_SMP_W];
  assign smp_count = out_word[jlsd_pkg::JLSD_F_CNT +: jlsd_pkg::JLSD_CNT_W];
  assign smp_spc = out_word[jlsd_pkg::JLSD_F_SPC +: jlsd_pkg::JLSD_SPC_W];
  assign smp_convs = out_word[jlsd_pkg::JLSD_F_CNV +: jlsd_pkg::JLSD_CNV_W];
endmodule // jlsd_demapper

//--- core/jlsd_fifo.sv
// Sample FIFO with a registered output word.
// Assumes writer and reader share the clock; reset is already synchronised.
`timescale 1ns/10ps
module jlsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ready_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  wire do_wr = wr_valid & ready_reg;
  wire mem_empty = (count_reg == '0);
  wire out_free = ~out_valid_reg | rd_ready;
  wire do_mv = ~mem_empty & out_free;
  wire [AW-1:0] wr_ptr_inc = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                             : wr_ptr_reg + 1'b1;
  wire [AW-1:0] rd_ptr_inc = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                             : rd_ptr_reg + 1'b1;

  assign count_next = count_reg + CW'(do_wr) - CW'(do_mv);
  assign wr_ready = ready_reg;
  assign rd_valid = out_valid_reg;
  assign rd_data = out_data_reg;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= do_wr ? wr_ptr_inc : wr_ptr_reg;
      rd_ptr_reg <= do_mv ? rd_ptr_inc : rd_ptr_reg;
      count_reg <= count_next;
      ready_reg <= (count_next < CW'(DEPTH));
    end
  end

  // Output word is a register so the reader never sees memory read timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (out_free) begin
      out_valid_reg <= ~mem_empty;
      out_data_reg <= mem_empty ? out_data_reg : mem[rd_ptr_reg];
    end
  end
endmodule // jlsd_fifo

//--- core/jlsd_sync_mon.sv
// Link synchronisation request from per-lane alignment flags.
// Assumes alignment flags come from deframer logic on the same clock.
`timescale 1ns/10ps
module jlsd_sync_mon (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] lane_used,
  input wire logic [7:0] lane_aligned,
  output logic link_sync_request
);
  logic [2:0] good_cnt_reg;
  logic req_reg;

  wire all_ok = (lane_used != 8'h00) & (&(lane_aligned | ~lane_used));
  wire cnt_done = (good_cnt_reg == jlsd_pkg::JLSD_RESYNC_CYC);

  assign link_sync_request = req_reg;

  // Drop at once on any misaligned used lane; rise only after a calm spell
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good_cnt_reg <= '0;
      req_reg <= 1'b0;
    end else begin
      good_cnt_reg <= !all_ok ? 3'h0 : (cnt_done ? good_cnt_reg
                                        : good_cnt_reg + 3'h1); // RULE17
      req_reg <= all_ok & cnt_done; // RULE17
    end
  end
endmodule // jlsd_sync_mon

//--- include/jlsd_pkg.sv
// Shared constants, mode table and field layouts for the lane demapper.
// Assumes one frame of all lanes arrives per beat on the processing clock.
package jlsd_pkg;

  localparam int JLSD_LANES = 8;
  localparam int JLSD_OCTS = 8;
  localparam int JLSD_OW = 8;
  localparam int JLSD_NIB = 4;
  localparam int JLSD_SW = 16;
  localparam int JLSD_SLOTS = 16;
  localparam int JLSD_LANE_W = JLSD_OCTS * JLSD_OW;
  localparam int JLSD_IN_W = JLSD_LANES * JLSD_LANE_W;
  localparam int JLSD_SMP_W = JLSD_SLOTS * JLSD_SW;
  localparam int JLSD_CNT_W = 5;
  localparam int JLSD_SPC_W = 4;
  localparam int JLSD_CNV_W = 3;
  localparam int JLSD_WORD_W = JLSD_SMP_W + JLSD_CNT_W + JLSD_SPC_W
                               + JLSD_CNV_W;
  localparam int JLSD_FIFO_DEPTH = 16;
  // Field positions inside a FIFO word
  localparam int JLSD_F_DATA = 0;
  localparam int JLSD_F_CNT = JLSD_SMP_W;
  localparam int JLSD_F_SPC = JLSD_F_CNT + JLSD_CNT_W;
  localparam int JLSD_F_CNV = JLSD_F_SPC + JLSD_SPC_W;
  // Aligned cycles needed before the sync request is raised again
  localparam logic [2:0] JLSD_RESYNC_CYC = 3'h4;

  localparam logic [4:0] JLSD_MODE_0 = 5'h00;
  localparam logic [4:0] JLSD_MODE_1 = 5'h01;
  localparam logic [4:0] JLSD_MODE_2 = 5'h02;
  localparam logic [4:0] JLSD_MODE_3 = 5'h03;
  localparam logic [4:0] JLSD_MODE_4 = 5'h04;
  localparam logic [4:0] JLSD_MODE_5 = 5'h05;
  localparam logic [4:0] JLSD_MODE_6 = 5'h06;
  localparam logic [4:0] JLSD_MODE_7 = 5'h07;
  localparam logic [4:0] JLSD_MODE_9 = 5'h09;
  localparam logic [4:0] JLSD_MODE_11 = 5'h0b;
  localparam logic [4:0] JLSD_MODE_12 = 5'h0c;
  localparam logic [4:0] JLSD_MODE_19 = 5'h13;
  localparam logic [4:0] JLSD_MODE_21 = 5'h15;
  localparam logic [4:0] JLSD_MODE_22 = 5'h16;

  typedef struct packed {
    logic ok;
    logic hd12;
    logic [3:0] lanes;
    logic [2:0] convs;
    logic [3:0] octs;
    logic [3:0] spc;
  } jlsd_mode_s;

  function automatic jlsd_mode_s jlsd_mode_lookup(input logic [4:0] mode);
    jlsd_mode_s m;
    m = '{1'b0, 1'b0, 4'h0, 3'h0, 4'h0, 4'h0};
    case (mode)
      JLSD_MODE_0: m = '{1'b1, 1'b0, 4'h1, 3'h2, 4'h4, 4'h1};
      JLSD_MODE_1: m = '{1'b1, 1'b0, 4'h2, 3'h4, 4'h4, 4'h1};
      JLSD_MODE_2: m = '{1'b1, 1'b0, 4'h3, 3'h6, 4'h4, 4'h1};
      JLSD_MODE_3: m = '{1'b1, 1'b0, 4'h2, 3'h2, 4'h2, 4'h1};
      JLSD_MODE_4: m = '{1'b1, 1'b0, 4'h4, 3'h4, 4'h2, 4'h1};
      JLSD_MODE_5: m = '{1'b1, 1'b1, 4'h1, 3'h2, 4'h3, 4'h1};
      JLSD_MODE_6: m = '{1'b1, 1'b1, 4'h2, 3'h4, 4'h3, 4'h1};
      JLSD_MODE_7: m = '{1'b1, 1'b0, 4'h1, 3'h4, 4'h8, 4'h1};
      JLSD_MODE_9: m = '{1'b1, 1'b0, 4'h4, 3'h2, 4'h2, 4'h2};
      JLSD_MODE_11: m = '{1'b1, 1'b0, 4'h8, 3'h2, 4'h2, 4'h4};
      JLSD_MODE_12: m = '{1'b1, 1'b1, 4'h8, 3'h2, 4'h3, 4'h8};
      JLSD_MODE_19: m = '{1'b1, 1'b0, 4'h4, 3'h1, 4'h2, 4'h4};
      JLSD_MODE_21: m = '{1'b1, 1'b0, 4'h8, 3'h1, 4'h2, 4'h8};
      JLSD_MODE_22: m = '{1'b1, 1'b1, 4'h4, 3'h2, 4'h3, 4'h4};
      default: m = '{1'b0, 1'b0, 4'h0, 3'h0, 4'h0, 4'h0};
    endcase
    return m;
  endfunction

endpackage

//--- tb/jlsd_demapper_chk.sv
// Port-level assertions for the lane demapper.
// Assumes it is bound onto the demapper top; one clock domain.
`timescale 1ns/10ps
module jlsd_demapper_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [4:0] cfg_link_mode,
  input wire logic [7:0] lane_aligned,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic link_sync_request,
  input wire logic mode_error,
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic [255:0] smp_data,
  input wire logic [4:0] smp_count,
  input wire logic [3:0] smp_spc,
  input wire logic [2:0] smp_convs
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_b && !$past(rst_b) |-> !smp_valid && !in_ready && !link_sync_request)
    else $error("outputs active during reset");
  stall_hold_a: assert property (
    smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
    else $error("sample word changed while stalled");
  slot_count_a: assert property (
    smp_valid |-> smp_count == 5'(smp_spc) * 5'(smp_convs))
    else $error("slot count differs from mode geometry");
  unused_zero_a: assert property (
    smp_valid |-> (smp_data >> {smp_count, 4'h0}) == '0)
    else $error("unused slots not zero");
  frame_latency_a: assert property (
    in_valid && in_ready && link_sync_request && !mode_error && !smp_valid
    |-> ##[1:2] smp_valid) else $error("kept frame not delivered");
  sync_drop_a: assert property (
    !lane_aligned[0] && link_sync_request |=> !link_sync_request)
    else $error("sync request held with lane 0 lost");
  sync_fall_a: assert property (
    $fell(link_sync_request) |-> $past(lane_aligned) != 8'hff || mode_error)
    else $error("sync request fell with lanes aligned in a good mode");
  sync_rise_a: assert property (
    $rose(link_sync_request) |-> $past(lane_aligned[0])
    && $past(lane_aligned[0], 4)) else $error("sync request rose early");
  mode_check_a: assert property (
    $stable(cfg_link_mode) [*3] |-> mode_error == !(cfg_link_mode inside
    {[5'h00:5'h07], 5'h09, 5'h0b, 5'h0c, 5'h13, 5'h15, 5'h16}))
    else $error("mode error flag wrong");
endmodule // jlsd_demapper_chk
bind jlsd_demapper jlsd_demapper_chk u_chk (.mclk, .rst_b, .cfg_link_mode,
  .lane_aligned, .in_valid, .in_ready, .link_sync_request, .mode_error,
  .smp_valid, .smp_ready, .smp_data, .smp_count, .smp_spc, .smp_convs);

//--- tb/jlsd_demapper_tb.sv
// Self-checking bench: random samples through the transmitter model.
// Assumes package, FIFO, sync monitor and demapper compile first.
`timescale 1ns/10ps
module jlsd_demapper_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] cfg_link_mode = 5'h00;
  logic [7:0] lane_aligned = 8'hff;
  logic in_valid = 1'b0;
  logic smp_ready = 1'b0;
  logic [3:0] lanes = 4'h1;
  logic [3:0] octs = 4'h4;
  logic [3:0] cv = 4'h2;
  logic [3:0] spc = 4'h1;
  logic [255:0] smp = '0;
  logic [511:0] noise = '0;
  logic [511:0] in_octets;
  logic in_ready, link_sync_request, mode_error, smp_valid;
  logic [255:0] smp_data;
  logic [4:0] smp_count;
  logic [3:0] smp_spc;
  logic [2:0] smp_convs;
  wire [267:0] got = {smp_data, smp_count, smp_spc, smp_convs};
  logic [267:0] q[$];
  logic stall = 1'b0;
  logic took_last = 1'b1;
  logic t;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int acc;
  // Mode, lanes, converters, octets per lane, samples per converter
  logic [23:0] mt [14] = '{24'h00_1241, 24'h01_2441, 24'h02_3641,
    24'h03_2221, 24'h04_4421, 24'h05_1231, 24'h06_2431, 24'h07_1481,
    24'h09_4222, 24'h0b_8224, 24'h0c_8238, 24'h13_4124, 24'h15_8128,
    24'h16_4234};

  always #4 mclk = ~mclk;
  jlsd_tx_model tx (.lanes(lanes), .octs(octs), .sync_req(link_sync_request),
    .smp(smp), .noise(noise), .octets(in_octets));
  jlsd_demapper DUT (.mclk, .rst_b, .cfg_link_mode, .lane_aligned, .in_valid,
    .in_ready, .in_octets, .link_sync_request, .mode_error, .smp_valid,
    .smp_ready, .smp_data, .smp_count, .smp_spc, .smp_convs);

  task automatic chk(input string nm, input logic [267:0] s,
    input logic [267:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [267:0] expw();
    logic [255:0] d;
    d = '0;
    for (int g = 0; g < 16; g++)
      if (g < cv * spc) d[g*16 +: 16] = octs == 4'h3 ?
        {4'h0, smp[g*16 +: 12]} : smp[g*16 +: 16];
    return {d, 5'(cv) * 5'(spc), spc, cv[2:0]};
  endfunction

  // A refused frame is offered again unchanged
  task automatic beat(input logic keep);
    @(negedge mclk);
    if (took_last) begin
      for (int i = 0; i < 8; i++) smp[i*32 +: 32] = $urandom;
      for (int i = 0; i < 16; i++) noise[i*32 +: 32] = $urandom;
    end
    in_valid = 1'b1;
    // Ready comes from a flop, so its value now holds at the next edge
    t = in_ready;
    @(posedge mclk);
    took_last = t;
    if (t && keep) q.push_back(expw());
  endtask

  task automatic send(input logic keep);
    beat(keep);
    for (int w = 0; w < 200 && !t; w++) beat(keep);
  endtask

  task automatic drain();
    @(negedge mclk);
    in_valid = 1'b0;
    took_last = 1'b1;
    for (int w = 0; w < 500 && q.size() > 0; w++) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic setmode(input logic [23:0] e);
    drain();
    cfg_link_mode = e[20:16];
    {lanes, cv, octs, spc} = e[15:0];
    repeat (3) @(negedge mclk);
  endtask

  always @(negedge mclk) smp_ready <= !stall && ($urandom % 3 != 0);
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
    if (smp_valid === 1'b1 && smp_ready === 1'b1) begin
      if (q.size() == 0) chk("extra word", 268'(1), 268'(0));
      else chk("word", got, q.pop_front());
    end
  end

  initial begin
    void'($urandom(32'hb542_46f4));
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    for (int w = 0; w < 40 && !link_sync_request; w++) @(posedge mclk);
    foreach (mt[k]) begin
      setmode(mt[k]);
      repeat (6) send(1'b1);
    end
    setmode(mt[9]);
    stall = 1'b1;
    acc = 0;
    repeat (24) begin
      beat(1'b1);
      acc += t;
    end
    chk("fill depth", 268'(acc), 268'(17));
    stall = 1'b0;
    setmode(mt[4]);
    lane_aligned = 8'hdf;
    repeat (4) @(negedge mclk);
    chk("unused lane", 268'(link_sync_request), 268'(1));
    lane_aligned = 8'hfa;
    @(negedge mclk);
    chk("sync drop", 268'(link_sync_request), 268'(0));
    repeat (3) beat(1'b0);
    drain();
    lane_aligned = 8'hff;
    for (int w = 0; w < 20 && !link_sync_request; w++) @(posedge mclk);
    chk("sync back", 268'(link_sync_request), 268'(1));
    setmode(24'h08_4211);
    @(negedge mclk);
    chk("bad mode", 268'(mode_error), 268'(1));
    repeat (3) beat(1'b0);
    setmode(mt[13]);
    // The link regains its sync only a while after leaving an unsupported mode
    for (int w = 0; w < 20 && !link_sync_request; w++) @(posedge mclk);
    chk("sync after mode", 268'(link_sync_request), 268'(1));
    repeat (3) send(1'b1);
    drain();
    chk("queue empty", 268'(q.size()), 268'(0));
    conclude();
  end
endmodule // jlsd_demapper_tb

//--- tb/jlsd_tx_model.sv
// Link transmitter stand-in: packs converter samples into lane octets.
// Assumes the bench supplies the mode geometry and a noise pattern.
`timescale 1ns/10ps
module jlsd_tx_model (
  input wire logic [3:0] lanes,
  input wire logic [3:0] octs,
  input wire logic sync_req,
  input wire logic [255:0] smp,
  input wire logic [511:0] noise,
  output logic [511:0] octets
);
  always_comb begin
    // Unused octets carry noise so stale data never passes for a match
    octets = noise;
    for (int l = 0; l < 8; l++) begin
      for (int p = 0; p < 4; p++) begin
        if (l < lanes && octs != 4'h3 && 2 * p < octs) begin
          octets[(l*8+2*p)*8 +: 16] = {smp[(l*octs/2+p)*16 +: 8],
            smp[(l*octs/2+p)*16+8 +: 8]};
        end
      end
      if (l < lanes && octs == 4'h3) begin
        octets[l*64 +: 24] = {smp[l*32+16 +: 8], smp[l*32 +: 4],
          smp[l*32+24 +: 4], smp[l*32+4 +: 8]};
      end
    end
    if (!sync_req) begin
      octets = {64{8'hbc}};
    end
  end
endmodule // jlsd_tx_model
